// >>> rtl/escape_pkg.sv
// constants, register map and state codes for the command mode escape detector
// assumes a single 50 MHz system clock and a byte-wide receive stream on that clock
package escape_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_TICK_NS = 1_000_000;
  localparam int MS_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int TENTH_MS = 100;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_ESC = 8'h00;
  localparam logic [7:0] ADDR_GUARD = 8'h04;
  localparam logic [7:0] ADDR_TMO = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_LEAVE_BIT = 0;
  localparam int CTRL_CMD_OK_BIT = 1;
  localparam int CTRL_FS_GO_BIT = 2;
  localparam int STAT_CMD_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_FRAMED_BIT = 2;
  localparam int STAT_RANGE_BIT = 3;
  localparam int STAT_REPLY_BIT = 4;
  localparam int STAT_FAIL_BIT = 5;
  localparam logic [7:0] ESC_RESET = 8'h2B;
  localparam logic [10:0] GUARD_RESET = 11'h3E8;
  localparam logic [10:0] GUARD_MIN = 11'h002;
  localparam logic [10:0] GUARD_MAX = 11'h6D3;
  localparam logic [12:0] TMO_RESET = 13'h0064;
  localparam logic [12:0] TMO_MIN = 13'h0002;
  localparam logic [12:0] TMO_MAX = 13'h1770;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // ****************************************
  // reply text layout
  // ****************************************
  localparam logic [3:0] REPLY_ERR_FIRST = 4'h0;
  localparam logic [3:0] REPLY_ERR_LAST = 4'h8;
  localparam logic [3:0] REPLY_OK_FIRST = 4'h9;
  localparam logic [3:0] REPLY_OK_LAST = 4'hB;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b000,
    ST_READY = 3'b001,
    ST_GOT1 = 3'b011,
    ST_GOT2 = 3'b010,
    ST_GOT3 = 3'b110,
    ST_CMD = 3'b111
  } esc_state_t;

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

endpackage

// >>> rtl/ms_tick_gen.sv
// millisecond and hundred-millisecond tick generator
// assumes clk_sys free running; ticks are one-cycle pulses
`timescale 1ns/100ps
module ms_tick_gen import escape_pkg::*; #(
  parameter int MS_CYCLES_P = MS_CYCLES,
  parameter int TENTH_P = TENTH_MS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  output logic ms_tick,
  output logic tenth_tick
);
  localparam int DW = $clog2(MS_CYCLES_P);
  localparam int TW = $clog2(TENTH_P);

  logic [DW-1:0] div_reg;
  logic [TW-1:0] tenth_reg;

  // ****************************************
  // dividers
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
      ms_tick <= 1'b0;
    end else if (div_reg == DW'(MS_CYCLES_P - 1)) begin
      div_reg <= '0;
      ms_tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      ms_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tenth_reg <= '0;
      tenth_tick <= 1'b0;
    end else if (ms_tick && tenth_reg == TW'(TENTH_P - 1)) begin
      tenth_reg <= '0;
      tenth_tick <= 1'b1;
    end else begin
      if (ms_tick) begin
        tenth_reg <= tenth_reg + 1'b1;
      end
      tenth_tick <= 1'b0;
    end
  end
endmodule

// >>> rtl/reply_rom.sv
// constant text store for storage command replies, registered read data
// assumes the address is held until the data have been taken
`timescale 1ns/100ps
module reply_rom (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] addr,
  output logic [7:0] rdata
);
  function automatic logic [7:0] text_at(input logic [3:0] a);
    unique case (a)
      4'h0: text_at = 8'h45;
      4'h1: text_at = 8'h46;
      4'h2: text_at = 8'h53;
      4'h3: text_at = 8'h20;
      4'h4: text_at = 8'h66;
      4'h5: text_at = 8'h61;
      4'h6: text_at = 8'h69;
      4'h7: text_at = 8'h6C;
      4'h8: text_at = 8'h0D;
      4'h9: text_at = 8'h4F;
      4'hA: text_at = 8'h4B;
      4'hB: text_at = 8'h0D;
      default: text_at = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= text_at(addr);
    end
  end
endmodule

// >>> rtl/command_mode_escape_detector.sv
// escape sequence detector and command mode controller
// assumes rx bytes come from a receiver on clk_sys, and a storage engine answers fs_start
//
// Notes on behaviour
// RULE1 - the escape character is an 8-bit setting taking any value, 0x2B after reset.
// RULE2 - three escape characters in a row, all within one guard interval, are needed.
// RULE3 - the line must be silent for the guard interval before the first and after the third.
// RULE4 - the guard interval counts milliseconds, 0x2 to 0x6D3, default 0x3E8.
// RULE5 - command mode falls back to the earlier operation when no valid command comes in time.
// RULE6 - the inactivity timeout counts 100 ms units, 2 to 0x1770, default 0x64.
// RULE7 - the leave command exits command mode at once and commits all pending settings.
// RULE8 - the host should choose a printable escape character, though any byte works.
// RULE9 - storage commands run only in command mode and hold off other commands until done; a leave or timeout in the start cycle still exits command mode.
// RULE10 - a failed storage command answers with E, capitals, a space and text; success says OK.
// RULE11 - framed mode select zero means transparent operation, nonzero means framed operation.
// RULE12 - a wrong byte or a byte inside a silence interval abandons the sequence and restarts.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module command_mode_escape_detector import escape_pkg::*; #(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic pass_valid,
  output logic [7:0] pass_data,
  output logic cmd_rx_valid,
  output logic [7:0] cmd_rx_data,
  output logic cmd_mode,
  output logic framed_mode,
  output logic commit,
  output logic fs_start,
  input wire logic fs_done,
  input wire logic fs_ok,
  input wire logic reply_ready,
  output logic reply_valid,
  output logic [7:0] reply_data
);
  esc_state_t state_reg, state_next;
  logic ms_tick, tenth_tick;
  logic [7:0] esc_pend_reg, esc_act_reg;
  logic [10:0] guard_pend_reg, guard_act_reg;
  logic [12:0] tmo_pend_reg, tmo_act_reg;
  logic [1:0] mode_pend_reg, mode_act_reg;
  logic range_err_reg;
  logic [10:0] sil_cnt_reg;
  logic [12:0] tmo_cnt_reg;
  logic fs_busy_reg, fail_reg;
  logic rply_run_reg, rply_rdy_reg;
  logic [3:0] rply_addr_reg, rply_last_reg;
  logic [7:0] rom_data;
  logic [31:0] rdata_reg;
  logic pass_valid_reg, cmd_rx_valid_reg, cmd_mode_reg, framed_reg, commit_reg;
  logic [7:0] pass_data_reg;
  logic fs_start_reg, reply_valid_reg;
  logic [7:0] reply_data_reg;
  logic ctrl_wr, leave_go, cmd_ok_go, fs_go, esc_match, tmo_hit;

  // ****************************************
  // time base and reply text
  // ****************************************
  ms_tick_gen #(.MS_CYCLES_P(MS_CYCLES_P), .TENTH_P(TENTH_MS)) u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ms_tick(ms_tick),
    .tenth_tick(tenth_tick)
  );

  reply_rom u_rom (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .addr(rply_addr_reg),
    .rdata(rom_data)
  );

  // ****************************************
  // command decode
  // ****************************************
  assign ctrl_wr = reg_wr && reg_addr == ADDR_CTRL;
  assign esc_match = rx_valid && rx_data == esc_act_reg;
  assign leave_go = ctrl_wr && reg_wdata[CTRL_LEAVE_BIT] && state_reg == ST_CMD && !fs_busy_reg; // RULE9
  assign cmd_ok_go = ctrl_wr && reg_wdata[CTRL_CMD_OK_BIT] && state_reg == ST_CMD && !fs_busy_reg;
  assign fs_go = ctrl_wr && reg_wdata[CTRL_FS_GO_BIT] && state_reg == ST_CMD && !fs_busy_reg; // RULE9
  assign tmo_hit = state_reg == ST_CMD && !fs_busy_reg && tmo_cnt_reg >= tmo_act_reg; // RULE5

  // ****************************************
  // settings, pending and active
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      esc_pend_reg <= ESC_RESET; // RULE1
      guard_pend_reg <= GUARD_RESET;
      tmo_pend_reg <= TMO_RESET;
      mode_pend_reg <= MODE_RESET;
      range_err_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_ESC) begin
        esc_pend_reg <= reg_wdata[7:0]; // RULE1 RULE8
      end
      if (reg_wr && reg_addr == ADDR_MODE) begin
        mode_pend_reg <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == ADDR_GUARD) begin
        if (in_range(reg_wdata[15:0], {5'h00, GUARD_MIN}, {5'h00, GUARD_MAX})) begin
          guard_pend_reg <= reg_wdata[10:0]; // RULE4
        end
      end
      if (reg_wr && reg_addr == ADDR_TMO) begin
        if (in_range(reg_wdata[15:0], {3'h0, TMO_MIN}, {3'h0, TMO_MAX})) begin
          tmo_pend_reg <= reg_wdata[12:0]; // RULE6
        end
      end
      if (reg_wr && reg_addr == ADDR_GUARD && reg_wdata[31:16] == 16'h0000 &&
          in_range(reg_wdata[15:0], {5'h00, GUARD_MIN}, {5'h00, GUARD_MAX})) begin
        range_err_reg <= range_err_reg;
      end else if ((reg_wr && reg_addr == ADDR_GUARD) || (reg_wr && reg_addr == ADDR_TMO &&
          !in_range(reg_wdata[15:0], {3'h0, TMO_MIN}, {3'h0, TMO_MAX}))) begin
        range_err_reg <= 1'b1;
      end else if (reg_rd && reg_addr == ADDR_STATUS) begin
        range_err_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      esc_act_reg <= ESC_RESET;
      guard_act_reg <= GUARD_RESET;
      tmo_act_reg <= TMO_RESET;
      mode_act_reg <= MODE_RESET;
    end else if (leave_go) begin
      esc_act_reg <= esc_pend_reg; // RULE7
      guard_act_reg <= guard_pend_reg;
      tmo_act_reg <= tmo_pend_reg;
      mode_act_reg <= mode_pend_reg;
    end
  end

  // ****************************************
  // escape sequence state machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_WAIT: begin
        if (!rx_valid && sil_cnt_reg >= guard_act_reg) begin
          state_next = ST_READY; // RULE3
        end
      end
      ST_READY: begin
        if (rx_valid) begin
          state_next = esc_match ? ST_GOT1 : ST_WAIT; // RULE12
        end
      end
      ST_GOT1: begin
        if (rx_valid) begin
          state_next = esc_match ? ST_GOT2 : ST_WAIT; // RULE2 RULE12
        end else if (sil_cnt_reg >= guard_act_reg) begin
          state_next = ST_WAIT;
        end
      end
      ST_GOT2: begin
        if (esc_match && sil_cnt_reg < guard_act_reg) begin
          state_next = ST_GOT3; // RULE2
        end else if (rx_valid || sil_cnt_reg >= guard_act_reg) begin
          state_next = ST_WAIT; // RULE12
        end
      end
      ST_GOT3: begin
        if (rx_valid) begin
          state_next = ST_WAIT; // RULE12
        end else if (sil_cnt_reg >= guard_act_reg) begin
          state_next = ST_CMD; // RULE3
        end
      end
      ST_CMD: begin
        if (leave_go || tmo_hit) begin
          state_next = ST_WAIT; // RULE5 RULE7
        end
      end
      default: state_next = ST_WAIT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // silence and inactivity counters
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sil_cnt_reg <= '0;
    end else if (rx_valid && !(state_reg == ST_GOT1 && esc_match)) begin
      sil_cnt_reg <= '0; // RULE12
    end else if (ms_tick && sil_cnt_reg != 11'h7FF) begin
      sil_cnt_reg <= sil_cnt_reg + 11'h001; // RULE4
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tmo_cnt_reg <= '0;
    end else if (state_reg != ST_CMD || cmd_ok_go || fs_go || fs_busy_reg) begin
      tmo_cnt_reg <= '0;
    end else if (tenth_tick && tmo_cnt_reg != 13'h1FFF) begin
      tmo_cnt_reg <= tmo_cnt_reg + 13'h0001; // RULE6
    end
  end

  // ****************************************
  // data steering and mode outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pass_valid_reg <= 1'b0;
      pass_data_reg <= 8'h00;
      cmd_rx_valid_reg <= 1'b0;
      cmd_mode_reg <= 1'b0;
      framed_reg <= 1'b0;
      commit_reg <= 1'b0;
    end else begin
      pass_valid_reg <= rx_valid && state_reg != ST_CMD;
      cmd_rx_valid_reg <= rx_valid && state_reg == ST_CMD && !fs_busy_reg; // RULE9
      if (rx_valid) begin
        pass_data_reg <= rx_data;
      end
      cmd_mode_reg <= state_next == ST_CMD;
      framed_reg <= mode_act_reg != 2'h0; // RULE11
      commit_reg <= leave_go; // RULE7
    end
  end

  // ****************************************
  // storage commands and replies
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fs_busy_reg <= 1'b0;
      fs_start_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      fs_start_reg <= fs_go; // RULE9
      if (fs_go) begin
        fs_busy_reg <= 1'b1;
      end else if (fs_done && fs_busy_reg && !rply_run_reg) begin
        fs_busy_reg <= 1'b1;
      end
      if (fs_busy_reg && rply_run_reg && rply_addr_reg == rply_last_reg && rply_rdy_reg &&
          (!reply_valid_reg || reply_ready)) begin
        fs_busy_reg <= 1'b0; // RULE9
      end
      if (fs_done && fs_busy_reg && !rply_run_reg) begin
        fail_reg <= !fs_ok;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rply_run_reg <= 1'b0;
      rply_rdy_reg <= 1'b0;
      rply_addr_reg <= REPLY_ERR_FIRST;
      rply_last_reg <= REPLY_ERR_LAST;
      reply_valid_reg <= 1'b0;
      reply_data_reg <= 8'h00;
    end else begin
      if (reply_valid_reg && reply_ready) begin
        reply_valid_reg <= 1'b0;
      end
      if (fs_done && fs_busy_reg && !rply_run_reg) begin
        rply_run_reg <= 1'b1;
        rply_rdy_reg <= 1'b0;
        rply_addr_reg <= fs_ok ? REPLY_OK_FIRST : REPLY_ERR_FIRST; // RULE10
        rply_last_reg <= fs_ok ? REPLY_OK_LAST : REPLY_ERR_LAST;
      end else if (rply_run_reg && !rply_rdy_reg) begin
        rply_rdy_reg <= 1'b1;
      end else if (rply_run_reg && (!reply_valid_reg || reply_ready)) begin
        reply_valid_reg <= 1'b1;
        reply_data_reg <= rom_data; // RULE10
        rply_rdy_reg <= 1'b0;
        if (rply_addr_reg == rply_last_reg) begin
          rply_run_reg <= 1'b0;
        end else begin
          rply_addr_reg <= rply_addr_reg + 4'h1;
        end
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ESC: rdata_reg <= {24'h000000, esc_pend_reg};
        ADDR_GUARD: rdata_reg <= {21'h0, guard_pend_reg};
        ADDR_TMO: rdata_reg <= {19'h0, tmo_pend_reg};
        ADDR_MODE: rdata_reg <= {30'h0, mode_pend_reg};
        ADDR_STATUS: rdata_reg <= {26'h0, fail_reg, rply_run_reg, range_err_reg,
                                   framed_reg, fs_busy_reg, cmd_mode_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pass_valid = pass_valid_reg;
  assign pass_data = pass_data_reg;
  assign cmd_rx_valid = cmd_rx_valid_reg;
  assign cmd_rx_data = pass_data_reg;
  assign cmd_mode = cmd_mode_reg;
  assign framed_mode = framed_reg;
  assign commit = commit_reg;
  assign fs_start = fs_start_reg;
  assign reply_valid = reply_valid_reg;
  assign reply_data = reply_data_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_third_char;
    state_reg == ST_GOT2 && esc_match && sil_cnt_reg < guard_act_reg;
  endsequence

  a_esc_reset_value: assert property (!$past(resetn) |-> esc_act_reg == ESC_RESET) // RULE1
    else $error("escape character not at reset value");
  a_three_in_row: assert property (state_reg == ST_GOT3 && $past(state_reg) != ST_GOT3
    |-> $past(state_reg) == ST_GOT2 && $past(esc_match)) // RULE2
    else $error("third escape state reached without escape byte");
  a_third_then_quiet: assert property (s_third_char |=> state_reg == ST_GOT3) // RULE2
    else $error("third escape character not taken");
  a_entry_silence: assert property (state_reg == ST_CMD && $past(state_reg) == ST_GOT3
    |-> $past(sil_cnt_reg) >= guard_act_reg && !$past(rx_valid)) // RULE3
    else $error("command mode entered without trailing silence");
  a_guard_range: assert property (guard_pend_reg >= GUARD_MIN && guard_pend_reg <= GUARD_MAX) // RULE4
    else $error("guard interval out of range");
  a_timeout_exit: assert property (tmo_hit && !leave_go |=> state_reg == ST_WAIT ##1 !cmd_mode) // RULE5
    else $error("inactivity timeout did not leave command mode");
  a_timeout_range: assert property (tmo_pend_reg >= TMO_MIN && tmo_pend_reg <= TMO_MAX) // RULE6
    else $error("timeout setting out of range");
  a_leave_commit: assert property (leave_go |=> commit && state_reg == ST_WAIT &&
    esc_act_reg == $past(esc_pend_reg) && guard_act_reg == $past(guard_pend_reg)) // RULE7
    else $error("leave command did not commit settings");
  a_storage_gate: assert property (fs_start |-> $past(state_reg) == ST_CMD && !$past(fs_busy_reg)) // RULE9
    else $error("storage command started outside command mode");
  a_error_first: assert property (fs_done && fs_busy_reg && !rply_run_reg && !fs_ok
    |-> ##[2:4] (reply_valid && reply_data == 8'h45)) // RULE10
    else $error("failed storage reply does not open with E");
  a_mode_select: assert property (##1 framed_mode == ($past(mode_act_reg) != 2'h0)) // RULE11
    else $error("framed mode output disagrees with setting");
  a_abandon_seq: assert property ((state_reg == ST_GOT1 || state_reg == ST_GOT2) && rx_valid &&
    !esc_match |=> state_reg == ST_WAIT && sil_cnt_reg == 11'h000) // RULE12
    else $error("wrong byte did not abandon sequence");
endmodule

// >>> verif/host_serial_model.sv
// host controller model driving the received byte stream of the detector
// assumes clk_sys from the bench; one byte is a one-cycle rx_valid pulse
`timescale 1ns/100ps
module host_serial_model #(
  parameter int MS_CYC = 10
) (
  input wire logic clk_sys,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  // ****************************************
  // byte and silence tasks
  // ****************************************
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end

  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask

  task automatic quiet(input int ms);
    repeat (ms * MS_CYC) @(posedge clk_sys);
  endtask

  // silence, three escape bytes one idle cycle apart, silence
  task automatic escape_seq(input logic [7:0] c, input int gap_ms);
    quiet(gap_ms);
    repeat (3) send(c);
    quiet(gap_ms);
  endtask
endmodule

// >>> verif/command_mode_escape_detector_bench.sv
// self-checking bench for the command mode escape detector
// assumes the host model drives rx; the bench is register master and storage engine
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module command_mode_escape_detector_bench import escape_pkg::*;;
  localparam int MSC = 10;
  logic clk_sys, resetn, rx_valid, reg_wr, reg_rd, pass_valid, cmd_rx_valid, cmd_mode;
  logic framed_mode, commit, fs_start, fs_done, fs_ok, reply_ready, reply_valid;
  logic [7:0] rx_data, reg_addr, pass_data, cmd_rx_data, reply_data;
  logic [31:0] reg_wdata, reg_rdata, v;
  int err_count = 0;
  int num_checks = 0;
  logic [7:0] ra [6] = '{ADDR_ESC, ADDR_GUARD, ADDR_TMO, ADDR_MODE, ADDR_STATUS, 8'h20};
  logic [31:0] rv [6] = '{{24'h0, ESC_RESET}, {21'h0, GUARD_RESET}, {19'h0, TMO_RESET},
    {30'h0, MODE_RESET}, 32'h0, 32'h0};

  command_mode_escape_detector #(.MS_CYCLES_P(MSC)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pass_valid(pass_valid), .pass_data(pass_data),
    .cmd_rx_valid(cmd_rx_valid), .cmd_rx_data(cmd_rx_data), .cmd_mode(cmd_mode),
    .framed_mode(framed_mode), .commit(commit), .fs_start(fs_start), .fs_done(fs_done),
    .fs_ok(fs_ok), .reply_ready(reply_ready), .reply_valid(reply_valid),
    .reply_data(reply_data)
  );

  host_serial_model #(.MS_CYC(MSC)) host_u (
    .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data)
  );

  // ****************************************
  // clock, watchdog and closing report
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // register and storage tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic storage(input logic ok, input logic [7:0] first, input int n);
    int got;
    logic [7:0] b0, bl;
    got = 0;
    wr(ADDR_CTRL, 32'h4);
    #1 `CHK(fs_start, 1'b1)
    host_u.send(8'h31);
    #1 `CHK(cmd_rx_valid, 1'b0)
    @(posedge clk_sys);
    fs_done <= 1'b1;
    fs_ok <= ok;
    @(posedge clk_sys);
    fs_done <= 1'b0;
    for (int k = 0; k < 200 && got < n; k++) begin
      @(posedge clk_sys);
      if (reply_valid === 1'b1 && reply_ready === 1'b1) begin
        if (got == 0) b0 = reply_data;
        bl = reply_data;
        got++;
      end
      reply_ready <= k[0] | ok;
    end
    reply_ready <= 1'b1;
    if (got != n) begin
      err_count++;
      end_sim();
    end
    `CHK(b0, first)
    `CHK(bl, 8'h0D)
    rd(ADDR_STATUS, v);
    `CHK(v[STAT_FAIL_BIT], ~ok)
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fs_done = 1'b0;
    fs_ok = 1'b0;
    reply_ready = 1'b1;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], v);
      `CHK(v, rv[i])
    end
    wr(ADDR_GUARD, 32'h6D4);
    rd(ADDR_STATUS, v);
    `CHK(v[STAT_RANGE_BIT], 1'b1)
    rd(ADDR_GUARD, v);
    `CHK(v, 32'h3E8)
    wr(ADDR_TMO, 32'h1);
    rd(ADDR_STATUS, v);
    `CHK(v[STAT_RANGE_BIT], 1'b1)
    host_u.send(8'h55);
    #1 `CHK({pass_valid, pass_data}, 9'h155)
    $display("test reset and ranges done");
    host_u.escape_seq(8'h2B, 1002);
    repeat (3) @(posedge clk_sys);
    `CHK(cmd_mode, 1'b1)
    storage(1'b0, 8'h45, 9);
    storage(1'b1, 8'h4F, 3);
    wr(ADDR_ESC, 32'h41);
    wr(ADDR_GUARD, 32'h2);
    wr(ADDR_TMO, 32'h2);
    wr(ADDR_MODE, 32'h1);
    rd(ADDR_ESC, v);
    `CHK(v, 32'h41)
    `CHK(framed_mode, 1'b0)
    wr(ADDR_CTRL, 32'h1);
    #1 `CHK(commit, 1'b1)
    @(posedge clk_sys);
    #1 `CHK({cmd_mode, framed_mode}, 2'b01)
    $display("test entry, storage and leave done");
    host_u.quiet(4);
    host_u.send(8'h41);
    host_u.send(8'h41);
    host_u.send(8'h42);
    host_u.send(8'h41);
    host_u.quiet(4);
    `CHK(cmd_mode, 1'b0)
    host_u.quiet(4);
    repeat (3) host_u.send(8'h41);
    repeat (5) @(posedge clk_sys);
    host_u.send(8'h41);
    host_u.quiet(4);
    `CHK(cmd_mode, 1'b0)
    $display("test abandoned sequences done");
    host_u.escape_seq(8'h41, 4);
    repeat (3) @(posedge clk_sys);
    `CHK(cmd_mode, 1'b1)
    host_u.send(8'h5A);
    #1 `CHK({cmd_rx_valid, cmd_rx_data, pass_valid}, 10'h2B4)
    host_u.quiet(50);
    `CHK(cmd_mode, 1'b1)
    wr(ADDR_CTRL, 32'h2);
    host_u.quiet(50);
    `CHK(cmd_mode, 1'b1)
    host_u.quiet(250);
    `CHK({cmd_mode, framed_mode}, 2'b01)
    $display("test timeout done");
    end_sim();
  end
endmodule
